// ---- src/cpsw_top.sv ----
// Purpose: Priority level part of the processor status word
// Assumes: Plain register port, read data one cycle after read strobe
// Notes: Other status word bits read as zero
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module cpsw_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input wire logic [cpsw_pkg::CPSW_AW-1:0] regAddr,
    input wire logic [cpsw_pkg::CPSW_DW-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [cpsw_pkg::CPSW_DW-1:0] regRdata,
    // Arbiter side
    output logic [3:0] effLevel,
    output logic userIntMask
);
    import cpsw_pkg::*;
    logic [2:0] priority_level_field_reg, priority_level_field_next;
    logic extended_priority_bit_reg, extended_priority_bit_next;
    logic nesting_disable_bit_reg, nesting_disable_bit_next;
    logic [CPSW_DW-1:0] rdata_reg, rdata_next;
    logic [3:0] levelW;
    logic maskW;
    logic fieldWrEn;
    logic coreWrEn;
    logic ctlWrEn;
    logic [2:0] wrFieldW;
    logic wrExtW;
    logic wrNestW;

    function automatic logic hit(input logic [CPSW_AW-1:0] a, input logic [CPSW_AW-1:0] b);
        hit = (a == b);
    endfunction

    // Write strobes per register index, decoded once here
    assign fieldWrEn = regWr && hit(regAddr, CPSW_ADDR_STATUS);
    assign coreWrEn = regWr && hit(regAddr, CPSW_ADDR_CORE);
    assign ctlWrEn = regWr && hit(regAddr, CPSW_ADDR_INTCTL);

    // Write data slices for the three stored fields
    assign wrFieldW = regWdata[CPSW_FLD_HI:CPSW_FLD_LO];
    assign wrExtW = regWdata[CPSW_EXT_POS];
    assign wrNestW = regWdata[CPSW_NSTD_POS];

    // Priority field next value, refused while nesting is disabled
    // The lock looks at the stored bit, so a field write in the cycle
    // right after the write that sets the lock is already refused
    always_comb begin
        priority_level_field_next = priority_level_field_reg;
        if (fieldWrEn && !nesting_disable_bit_reg) begin
            priority_level_field_next = wrFieldW; // [RULE1] [RULE5]
        end
        if (!rst_b) begin
            priority_level_field_next = CPSW_FLD_RST; // [RULE6]
        end
    end

    // Priority field register
    always_ff @(posedge clk) begin
        priority_level_field_reg <= priority_level_field_next;
    end

    // Extended level bit, held in core control
    always_comb begin
        extended_priority_bit_next = extended_priority_bit_reg;
        if (coreWrEn) begin
            extended_priority_bit_next = wrExtW; // [RULE3]
        end
        if (!rst_b) begin
            extended_priority_bit_next = 1'b0;
        end
    end

    // Extended level bit register
    always_ff @(posedge clk) begin
        extended_priority_bit_reg <= extended_priority_bit_next;
    end

    // Nesting disable bit, held in interrupt control
    always_comb begin
        nesting_disable_bit_next = nesting_disable_bit_reg;
        if (ctlWrEn) begin
            nesting_disable_bit_next = wrNestW; // [RULE5]
        end
        if (!rst_b) begin
            nesting_disable_bit_next = 1'b0;
        end
    end

    // Nesting disable register
    always_ff @(posedge clk) begin
        nesting_disable_bit_reg <= nesting_disable_bit_next;
    end

    // Read mux, unmapped reads zero
    // Data is registered, so it stands only in the cycle after the strobe
    // and the port shows zero in every other cycle
    always_comb begin
        rdata_next = CPSW_ZERO;
        if (regRd) begin
            case (regAddr)
                CPSW_ADDR_STATUS: rdata_next[CPSW_FLD_HI:CPSW_FLD_LO] = priority_level_field_reg;
                CPSW_ADDR_CORE: rdata_next[CPSW_EXT_POS] = extended_priority_bit_reg;
                CPSW_ADDR_INTCTL: rdata_next[CPSW_NSTD_POS] = nesting_disable_bit_reg;
                CPSW_ADDR_LEVEL: rdata_next = {11'h000, maskW, levelW};
                default: rdata_next = CPSW_ZERO;
            endcase
        end
        if (!rst_b) begin
            rdata_next = CPSW_ZERO;
        end
    end

    always_ff @(posedge clk) begin
        rdata_reg <= rdata_next;
    end

    // Effective level and mask, one cycle after field update
    // The arbiter sees a new field one edge after the write edge,
    // which is in time for its next decision
    cpsw_mask uMask (
        .clk(clk),
        .rst_b(rst_b),
        .fieldIn(priority_level_field_reg),
        .extBit(extended_priority_bit_reg),
        .levelOut(levelW),
        .maskOut(maskW)
    ); // [RULE6]

    // Outputs straight from registers
    assign regRdata = rdata_reg;
    assign effLevel = levelW;
    assign userIntMask = maskW;

    // Checks on the stored fields, the read port and the arbiter outputs
    // All run on the one clock; reset suspends them except the reset checks

    // A locked field never moves
    AST_LOCKED: assert property (@(posedge clk) disable iff (!rst_b) // [RULE5]
        nesting_disable_bit_reg |=> $stable(priority_level_field_reg))
        else $error("locked field changed");

    // A field write while locked is dropped
    AST_WRITE_REFUSED: assert property (@(posedge clk) disable iff (!rst_b) // [RULE5]
        fieldWrEn && nesting_disable_bit_reg
        |=> priority_level_field_reg == $past(priority_level_field_reg))
        else $error("locked field took a write");

    // A field write lands while the field is open
    AST_WRITE_TAKES: assert property (@(posedge clk) disable iff (!rst_b) // [RULE1] [RULE5]
        fieldWrEn && !nesting_disable_bit_reg
        |=> priority_level_field_reg == $past(wrFieldW))
        else $error("field write lost");

    // Core control write sets the extended bit
    AST_EXT_TAKES: assert property (@(posedge clk) disable iff (!rst_b) // [RULE3]
        coreWrEn
        |=> extended_priority_bit_reg == $past(wrExtW))
        else $error("extended bit write lost");

    // Interrupt control write sets nesting disable
    AST_NEST_TAKES: assert property (@(posedge clk) disable iff (!rst_b) // [RULE5]
        ctlWrEn
        |=> nesting_disable_bit_reg == $past(wrNestW))
        else $error("nesting disable write lost");

    // Field holds when no write addresses it
    AST_FIELD_HOLDS: assert property (@(posedge clk) disable iff (!rst_b) // [RULE1]
        !fieldWrEn
        |=> $stable(priority_level_field_reg))
        else $error("field moved without a write");

    // Extended bit holds when no write addresses it
    AST_EXT_HOLDS: assert property (@(posedge clk) disable iff (!rst_b) // [RULE3]
        !coreWrEn
        |=> $stable(extended_priority_bit_reg))
        else $error("extended bit moved without a write");

    // A new field reaches the arbiter two edges after the write
    AST_NEW_GOVERNS: assert property (@(posedge clk) disable iff (!rst_b) // [RULE6]
        fieldWrEn && !nesting_disable_bit_reg
        |=> ##1 effLevel[2:0] == $past(wrFieldW, 2))
        else $error("new level not applied");

    // With the extended bit clear, the mask follows the new field
    AST_NEW_MASKS: assert property (@(posedge clk) disable iff (!rst_b) // [RULE2] [RULE6]
        fieldWrEn && !nesting_disable_bit_reg && !extended_priority_bit_reg && !coreWrEn
        |=> ##1 userIntMask == ($past(wrFieldW, 2) == CPSW_FLD_MAX))
        else $error("new level did not set the mask");

    // Top level bit of the arbiter level is the stored extended bit
    AST_EXT_LEVEL: assert property (@(posedge clk) disable iff (!rst_b) // [RULE3]
        1'b1
        |=> effLevel[3] == $past(extended_priority_bit_reg))
        else $error("extended bit missing from level");

    // Stored extended bit masks the user interrupts
    AST_EXT_MASK_OUT: assert property (@(posedge clk) disable iff (!rst_b) // [RULE4]
        extended_priority_bit_reg
        |=> userIntMask)
        else $error("extended bit left interrupts open");

    // Status word read shows the field and zeros elsewhere
    AST_READBACK: assert property (@(posedge clk) disable iff (!rst_b) // [RULE1]
        regRd && hit(regAddr, CPSW_ADDR_STATUS)
        |=> regRdata[CPSW_FLD_HI:CPSW_FLD_LO] == $past(priority_level_field_reg)
            && (regRdata & ~CPSW_STAT_MASK) == CPSW_ZERO)
        else $error("status readback wrong");

    // Level readout shows the arbiter outputs of the strobe cycle
    AST_LEVEL_READ: assert property (@(posedge clk) disable iff (!rst_b) // [RULE3] [RULE4]
        regRd && hit(regAddr, CPSW_ADDR_LEVEL)
        |=> regRdata == {11'h000, $past(userIntMask), $past(effLevel)})
        else $error("level readout wrong");

    // Reset clears the field
    AST_RESET_ZERO: assert property (@(posedge clk) // [RULE6]
        !rst_b
        |=> priority_level_field_reg == CPSW_FLD_RST)
        else $error("field not cleared");

    // Reset clears every output
    AST_RESET_OUTS: assert property (@(posedge clk) // [RULE6]
        !rst_b
        |=> (effLevel == CPSW_LVL_W && !userIntMask && regRdata == CPSW_ZERO))
        else $error("outputs not cleared by reset");
endmodule

// ---- inc/cpsw_pkg.sv ----
// Purpose: Constants for the processor priority status word block
// Assumes: 16-bit register port, registers at word indices of our choosing
// Notes: Register indices and field positions of the port are our own choice
// Overview of operation
// RULE1 - Status word bits 7..5 hold the base priority level 0..7 in binary.
// RULE2 - A field value of 111 means level 7 and masks all user interrupts.
// RULE3 - Extended bit above the field forms a four-bit level, 8..15 when set.
// RULE4 - While the extended bit is 1, every user interrupt is masked.
// RULE5 - With nesting disable set, software writes to the field are ignored.
// RULE6 - Field clears at reset; a new value governs the next arbitration decision.
package cpsw_pkg;
    localparam int CPSW_AW = 4;
    localparam int CPSW_DW = 16;
    localparam logic [CPSW_AW-1:0] CPSW_ADDR_STATUS = 4'h0;
    localparam logic [CPSW_AW-1:0] CPSW_ADDR_CORE = 4'h1;
    localparam logic [CPSW_AW-1:0] CPSW_ADDR_INTCTL = 4'h2;
    localparam logic [CPSW_AW-1:0] CPSW_ADDR_LEVEL = 4'h3;
    localparam int CPSW_FLD_HI = 7;
    localparam int CPSW_FLD_LO = 5;
    localparam int CPSW_EXT_POS = 3;
    localparam int CPSW_NSTD_POS = 15;
    localparam logic [2:0] CPSW_FLD_RST = 3'h0;
    localparam logic [2:0] CPSW_FLD_MAX = 3'h7;
    localparam logic [3:0] CPSW_LVL_W = 4'h0;
    localparam logic [CPSW_DW-1:0] CPSW_ZERO = 16'h0000;
    localparam logic [CPSW_DW-1:0] CPSW_STAT_MASK = 16'h00E0;
endpackage

// ---- src/cpsw_mask.sv ----
// Purpose: Forms effective priority and the user interrupt mask
// Assumes: Inputs are registered in the same clock domain
// Notes: Registered outputs
`timescale 1ns/100ps
module cpsw_mask (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Level sources
    input wire logic [2:0] fieldIn,
    input wire logic extBit,
    // Results
    output logic [3:0] levelOut,
    output logic maskOut
);
    import cpsw_pkg::*;
    logic [3:0] level_reg, level_next;
    logic mask_reg, mask_next;

    // Combine extended bit with base field
    always_comb begin
        level_next = {extBit, fieldIn}; // [RULE3]
        mask_next = extBit || (fieldIn == CPSW_FLD_MAX); // [RULE2] [RULE4]
        if (!rst_b) begin
            level_next = CPSW_LVL_W;
            mask_next = 1'b0;
        end
    end

    // Register results
    always_ff @(posedge clk) begin
        level_reg <= level_next;
        mask_reg <= mask_next;
    end

    assign levelOut = level_reg;
    assign maskOut = mask_reg;

    // Extended bit masks every user interrupt on the next edge
    AST_EXT_MASKS: assert property (@(posedge clk) disable iff (!rst_b) // [RULE4]
        extBit |=> maskOut)
        else $error("extended bit did not mask");
    // Top field code masks and reports level seven
    AST_TOP_MASKS: assert property (@(posedge clk) disable iff (!rst_b) // [RULE2]
        (fieldIn == CPSW_FLD_MAX) |=> (maskOut && levelOut[2:0] == CPSW_FLD_MAX))
        else $error("level 7 did not mask");
    // Below the top code, without the extended bit, nothing is masked
    AST_LOW_OPEN: assert property (@(posedge clk) disable iff (!rst_b) // [RULE2] [RULE4]
        (!extBit && fieldIn != CPSW_FLD_MAX) |=> !maskOut)
        else $error("mask set at low level");
    // Effective level is the extended bit above the field
    AST_LEVEL_CAT: assert property (@(posedge clk) disable iff (!rst_b) // [RULE3]
        1'b1 |=> levelOut == {$past(extBit), $past(fieldIn)})
        else $error("level not concatenated");
endmodule

// ---- sim/test_cpu_priority_status_word.sv ----
// Purpose: Self-checking bench for the priority level part of the status word
// Assumes: Register port timing and index map as declared in cpsw_pkg
// Notes: Random writes mixed with corner cases; the bench mirrors the state
`timescale 1ns/100ps
module test_cpu_priority_status_word;
    import cpsw_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [CPSW_AW-1:0] regAddr = 4'h0;
    logic [CPSW_DW-1:0] regWdata = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [CPSW_DW-1:0] regRdata;
    logic [3:0] effLevel;
    logic userIntMask;
    int error_cnt = 0;
    int cmp_count = 0;
    int seed = 32'h40B0E80D;
    logic [2:0] fld = 3'h0;
    logic ext = 1'b0;
    logic nstd = 1'b0;
    logic [CPSW_DW-1:0] d;

    cpsw_top dut (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .effLevel(effLevel),
        .userIntMask(userIntMask));

    // Clock at 40 MHz
    initial forever #12.5 clk = ~clk;

    // Expected {mask, level} in level readout format
    function automatic logic [15:0] expLvl();
        return {11'h000, (ext | (fld == CPSW_FLD_MAX)), ext, fld};
    endfunction

    // Expected status word readout
    function automatic logic [15:0] expStat();
        return {8'h00, fld, 5'h00};
    endfunction

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    // One-cycle read strobe, data checked in the following cycle only
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 cmp(regRdata, exp);
    endtask

    // Arbiter outputs settle one edge after the write edge
    task automatic chkLvl();
        @(posedge clk);
        #1 cmp({11'h000, userIntMask, effLevel}, expLvl());
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog against a hung run
    initial begin
        repeat (6000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        chkLvl();
        rd(CPSW_ADDR_STATUS, CPSW_ZERO);
        wr(CPSW_ADDR_STATUS, 16'hFFFF);
        fld = CPSW_FLD_MAX;
        chkLvl();
        rd(CPSW_ADDR_STATUS, CPSW_STAT_MASK);
        for (int i = 0; i < 60; i++) begin
            d = 16'($random(seed));
            wr(CPSW_ADDR_INTCTL, d);
            nstd = d[CPSW_NSTD_POS];
            d = 16'($random(seed));
            wr(CPSW_ADDR_CORE, d);
            ext = d[CPSW_EXT_POS];
            d = 16'($random(seed));
            wr(CPSW_ADDR_STATUS, d);
            if (!nstd) begin
                fld = d[CPSW_FLD_HI:CPSW_FLD_LO];
            end
            chkLvl();
            wr({2'b01, d[1:0]}, ~d);
            rd(CPSW_ADDR_STATUS, expStat());
            rd(CPSW_ADDR_LEVEL, expLvl());
            rd(CPSW_ADDR_CORE, 16'(ext) << CPSW_EXT_POS);
            rd(CPSW_ADDR_INTCTL, 16'(nstd) << CPSW_NSTD_POS);
            rd({1'b1, d[10:8]}, CPSW_ZERO);
        end
        // Corner: open field at level 0, then lock it and try level 7
        wr(CPSW_ADDR_INTCTL, CPSW_ZERO);
        nstd = 1'b0;
        wr(CPSW_ADDR_CORE, CPSW_ZERO);
        ext = 1'b0;
        wr(CPSW_ADDR_STATUS, CPSW_ZERO);
        fld = CPSW_FLD_RST;
        chkLvl();
        wr(CPSW_ADDR_INTCTL, 16'h8000);
        nstd = 1'b1;
        wr(CPSW_ADDR_STATUS, CPSW_STAT_MASK);
        rd(CPSW_ADDR_STATUS, expStat());
        // Corner: extended bit alone masks at a low field
        wr(CPSW_ADDR_CORE, 16'h0008);
        ext = 1'b1;
        chkLvl();
        // Mid-run reset clears everything again
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        fld = CPSW_FLD_RST;
        ext = 1'b0;
        nstd = 1'b0;
        chkLvl();
        rd(CPSW_ADDR_INTCTL, CPSW_ZERO);
        rd(CPSW_ADDR_STATUS, expStat());
        wrap_up();
    end
endmodule
